// ### common/hbop_pkg.sv
package hbop_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 20000;
  localparam int DEAD_TIME_PS = 70000;
  localparam int LEAD_OFFSET_PS = 20000;
  localparam int TRAIL_OFFSET_PS = 6000;
  localparam int MIN_DEAD_PS = 5000;
  localparam int LEAD_PS_PER_KOHM = 2800;
  localparam int TRAIL_PS_PER_KOHM = 1350;
  localparam int OPEN_LIMIT_KOHM = 300;
  localparam int CNT_W = 16;
  localparam int DLY_W = 10;

  // Least times round up to whole cycles, at least one
  localparam int DEAD_CYC_I = (DEAD_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MIN_CYC_I = (MIN_DEAD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [CNT_W-1:0] DEAD_CYC = CNT_W'(DEAD_CYC_I < 1 ? 1 : DEAD_CYC_I);
  localparam logic [CNT_W-1:0] MIN_DEAD_CYC = CNT_W'(MIN_CYC_I < 1 ? 1 : MIN_CYC_I);
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic high_side_gate_out;
    logic low_side_gate_out;
    logic rect_a_ctrl;
    logic rect_b_ctrl;
  } hbop_drive_t;

  localparam hbop_drive_t DRIVE_OFF = 4'h0;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_LEAD = 3'h1,
    ST_ON = 3'h2,
    ST_TRAIL = 3'h3,
    ST_IDLE = 3'h4
  } hbop_state_t;

endpackage : hbop_pkg

// ### core/hbop_delay_calc.sv
`timescale 1ns/1ps
`default_nettype none
module hbop_delay_calc (
  input wire logic [hbop_pkg::DLY_W-1:0] rect_delay_set,
  input wire logic delay_pin_open,
  output logic [hbop_pkg::CNT_W-1:0] rect_lead_delay,
  output logic [hbop_pkg::CNT_W-1:0] rect_trail_delay
);
  import hbop_pkg::*;

  int lead_ps;
  int trail_ps;
  int lead_c;
  int trail_c;

  // ---------------------------------------------------------------
  // Resistor to cycle counts
  // ---------------------------------------------------------------
  always_comb begin
    lead_ps = int'(rect_delay_set) * LEAD_PS_PER_KOHM + LEAD_OFFSET_PS;
    trail_ps = int'(rect_delay_set) * TRAIL_PS_PER_KOHM + TRAIL_OFFSET_PS;
    lead_c = (lead_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    trail_c = (trail_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (delay_pin_open || int'(rect_delay_set) > OPEN_LIMIT_KOHM) begin
      rect_lead_delay = MIN_DEAD_CYC;
      rect_trail_delay = MIN_DEAD_CYC;
    end else begin
      rect_lead_delay = lead_c[CNT_W-1:0];
      rect_trail_delay = trail_c[CNT_W-1:0];
    end
  end

endmodule : hbop_delay_calc
`default_nettype wire

// ### core/hbop_phaser.sv
// Behaviour
// - High and low gates alternate, half oscillator rate while trail takes fewer cycles than deadtime
// - On-time capped: measured oscillator period minus deadtime, lead
// - No error current gives maximum duty
// - Rectifier A/B invert high/low gate respectively
// - High gate on: A off, B on
// - Low gate on: A on, B off
// - Idle between gate phases: both rectifiers on
// - Rectifier off lead before, on trail after
// - Lead, trail delays linear in resistance
// - Open or high resistance: minimum dead time
// - Thermal trip: standby, outputs off, restart after
// - Thermal shutdown discharges soft-start fully
// - Push-pull: same sequencing, ground-referenced
// - All drive outputs at half oscillator rate while trail takes fewer cycles than deadtime
// - Modulator trip ends active on-time
`timescale 1ns/1ps
`default_nettype none
module hbop_phaser (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic osc_tick,
  input wire logic pwm_trip,
  input wire logic err_current_present,
  input wire logic bias_ready,
  input wire logic thermal_trip,
  input wire logic push_pull_mode,
  input wire logic [hbop_pkg::DLY_W-1:0] rect_delay_set,
  input wire logic delay_pin_open,
  output hbop_pkg::hbop_drive_t drive,
  output logic bias_enable,
  output logic soft_start_discharge,
  output logic push_pull_active
);
  import hbop_pkg::*;

  typedef struct packed {
    hbop_state_t state;
    logic phase_low;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] osc_cnt;
    logic [CNT_W-1:0] osc_len;
    logic thermal;
    hbop_drive_t drive;
    logic bias_en;
    logic ss_dis;
    logic pp;
  } hbop_regs_t;

  hbop_regs_t r_q;
  hbop_regs_t r_d;
  logic [CNT_W-1:0] lead_cyc;
  logic [CNT_W-1:0] trail_cyc;
  logic [CNT_W-1:0] cap_cyc;
  logic run;

  hbop_delay_calc u_delay (
    .rect_delay_set(rect_delay_set),
    .delay_pin_open(delay_pin_open),
    .rect_lead_delay(lead_cyc),
    .rect_trail_delay(trail_cyc)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    // Raw flag too, so the outputs drop on the very next edge
    run = bias_ready && !thermal_trip && !r_q.thermal;
    // Measured oscillator period sets the duty cap for the next cycle
    cap_cyc = r_q.osc_len - DEAD_CYC - lead_cyc;
    if (r_q.osc_len <= DEAD_CYC + lead_cyc) begin
      cap_cyc = CNT_ONE;
    end
    if (osc_tick) begin
      r_d.osc_len = r_q.osc_cnt + CNT_ONE;
      r_d.osc_cnt = CNT_ZERO;
    end else begin
      r_d.osc_cnt = r_q.osc_cnt + CNT_ONE;
    end
    if (thermal_trip) begin
      r_d.thermal = 1'b1;
    end else if (r_q.thermal && !thermal_trip) begin
      r_d.thermal = 1'b0;
    end
    r_d.bias_en = !thermal_trip;
    r_d.ss_dis = thermal_trip || r_q.thermal;
    r_d.pp = push_pull_mode;
    if (r_q.cnt != CNT_ZERO) begin
      r_d.cnt = r_q.cnt - CNT_ONE;
    end
    unique case (r_q.state)
      ST_OFF: begin
        r_d.drive = DRIVE_OFF;
        r_d.phase_low = 1'b0;
        if (run && osc_tick) begin
          r_d.state = ST_LEAD;
          r_d.cnt = lead_cyc;
          r_d.drive.rect_a_ctrl = 1'b0;
          r_d.drive.rect_b_ctrl = 1'b1;
        end
      end
      ST_IDLE: begin
        r_d.drive.rect_a_ctrl = 1'b1;
        r_d.drive.rect_b_ctrl = 1'b1;
        if (osc_tick) begin
          r_d.state = ST_LEAD;
          r_d.cnt = lead_cyc;
          // Pull the opposite rectifier off a lead ahead of the gate
          if (r_q.phase_low) begin
            r_d.drive.rect_b_ctrl = 1'b0;
          end else begin
            r_d.drive.rect_a_ctrl = 1'b0;
          end
        end
      end
      ST_LEAD: begin
        if (r_q.cnt <= CNT_ONE) begin
          r_d.state = ST_ON;
          r_d.cnt = cap_cyc;
          r_d.drive.high_side_gate_out = !r_q.phase_low;
          r_d.drive.low_side_gate_out = r_q.phase_low;
          r_d.drive.rect_a_ctrl = r_q.phase_low;
          r_d.drive.rect_b_ctrl = !r_q.phase_low;
        end
      end
      ST_ON: begin
        // Trip ignored without error current: runs to the cap
        if ((pwm_trip && err_current_present) || r_q.cnt <= CNT_ONE) begin
          r_d.state = ST_TRAIL;
          r_d.cnt = trail_cyc;
          r_d.drive.high_side_gate_out = 1'b0;
          r_d.drive.low_side_gate_out = 1'b0;
        end
      end
      ST_TRAIL: begin
        if (r_q.cnt <= CNT_ONE) begin
          r_d.state = ST_IDLE;
          r_d.phase_low = !r_q.phase_low;
          r_d.drive.rect_a_ctrl = 1'b1;
          r_d.drive.rect_b_ctrl = 1'b1;
        end
      end
      default: begin
        r_d.state = ST_OFF;
      end
    endcase
    if (!run) begin
      r_d.state = ST_OFF;
      r_d.drive = DRIVE_OFF;
      r_d.phase_low = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      r_q <= '0;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  assign drive = r_q.drive;
  assign bias_enable = r_q.bias_en;
  assign soft_start_discharge = r_q.ss_dis;
  assign push_pull_active = r_q.pp;

endmodule : hbop_phaser
`default_nettype wire

// ### test/hbop_gate_load.sv
`timescale 1ns/1ps
`default_nettype none
module hbop_gate_load (
  input wire logic clk_sys,
  input wire hbop_pkg::hbop_drive_t drive,
  output logic shoot,
  output logic [7:0] hi_n,
  output logic [7:0] lo_n
);
  logic hi_q;
  logic lo_q;
  initial begin
    {shoot, hi_n, lo_n, hi_q, lo_q} = '0;
  end
  // Secondary short if a rectifier conducts against its own winding
  always @(posedge clk_sys) begin
    if (drive.high_side_gate_out && drive.rect_a_ctrl) shoot <= 1'b1;
    if (drive.low_side_gate_out && drive.rect_b_ctrl) shoot <= 1'b1;
    hi_q <= drive.high_side_gate_out;
    lo_q <= drive.low_side_gate_out;
    if (drive.high_side_gate_out && !hi_q) hi_n <= hi_n + 8'h01;
    if (drive.low_side_gate_out && !lo_q) lo_n <= lo_n + 8'h01;
  end
endmodule : hbop_gate_load
`default_nettype wire

// ### test/hbop_phaser_properties.sv
`timescale 1ns/1ps
`default_nettype none
module hbop_phaser_properties import hbop_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic pwm_trip,
  input wire logic err_current_present,
  input wire logic thermal_trip,
  input wire hbop_pkg::hbop_drive_t drive,
  input wire logic bias_enable,
  input wire logic soft_start_discharge
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_hi_rise; $rose(drive.high_side_gate_out); endsequence
  sequence s_hi_trip; drive.high_side_gate_out && pwm_trip && err_current_present; endsequence
  chk_gates_excl: assert property (!(drive.high_side_gate_out && drive.low_side_gate_out))
    else $error("both gates on");
  chk_hi_rects: assert property (drive.high_side_gate_out |-> !drive.rect_a_ctrl && drive.rect_b_ctrl)
    else $error("rect wrong in high phase");
  chk_lo_rects: assert property (drive.low_side_gate_out |-> drive.rect_a_ctrl && !drive.rect_b_ctrl)
    else $error("rect wrong in low phase");
  chk_reset_off: assert property ($past(!reset_n) |-> drive == DRIVE_OFF)
    else $error("outputs on after reset");
  chk_hi_lead: assert property (s_hi_rise |-> $past(!drive.rect_a_ctrl))
    else $error("no lead before high gate");
  chk_trip_end: assert property (s_hi_trip |-> ##[1:2] !drive.high_side_gate_out)
    else $error("trip ignored");
  chk_therm_off: assert property (thermal_trip |=> drive == DRIVE_OFF)
    else $error("outputs on in shutdown");
  chk_bias_off: assert property (thermal_trip |=> !bias_enable)
    else $error("bias on in shutdown");
  chk_ss_dump: assert property (thermal_trip |=> soft_start_discharge)
    else $error("soft-start kept");
endmodule : hbop_phaser_properties
bind hbop_phaser hbop_phaser_properties u_props (.clk_sys(clk_sys), .reset_n(reset_n),
  .pwm_trip(pwm_trip), .err_current_present(err_current_present),
  .thermal_trip(thermal_trip), .drive(drive), .bias_enable(bias_enable),
  .soft_start_discharge(soft_start_discharge));
`default_nettype wire

// ### test/tb_hbop_phaser.sv
`timescale 1ns/1ps
`default_nettype none
module tb_hbop_phaser;
  import hbop_pkg::*;
  logic clk_sys, reset_n, clk_en, osc_tick, pwm_trip, err, therm, bias_ready, pp, open;
  logic [9:0] dly;
  hbop_drive_t drive, held;
  logic bias_enable, ssd, pp_act, shoot;
  logic [7:0] hi_n, lo_n, m, oc;
  logic [15:0] w, last_w;
  int num_errors, n_tests;
  // Rows: pin open, kilohms, expected on-time at a 40-cycle oscillator
  int rows [4][3] = '{'{1, 0, 35}, '{0, 100, 21}, '{0, 10, 33}, '{0, 400, 35}};
  hbop_phaser u_hbop_phaser (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .osc_tick(osc_tick), .pwm_trip(pwm_trip), .err_current_present(err),
    .bias_ready(bias_ready), .thermal_trip(therm), .push_pull_mode(pp),
    .rect_delay_set(dly), .delay_pin_open(open), .drive(drive), .bias_enable(bias_enable),
    .soft_start_discharge(ssd), .push_pull_active(pp_act));
  hbop_gate_load u_hbop_gate_load (.clk_sys(clk_sys), .drive(drive), .shoot(shoot),
    .hi_n(hi_n), .lo_n(lo_n));
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    {oc, w, last_w} = '0;
    osc_tick = 0;
  end
  always @(posedge clk_sys) begin
    oc <= (oc == 8'h27) ? 8'h00 : oc + 8'h01;
    osc_tick <= (oc == 8'h27);
    if (drive.high_side_gate_out) w <= w + 16'h0001;
    else if (w != 0) begin
      last_w <= w;
      w <= 0;
    end
  end
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch t=%0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : wt
  task end_sim;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    num_errors++;
    end_sim;
  end
  initial begin
    {reset_n, pwm_trip, err, therm, pp, dly} = '0;
    {clk_en, bias_ready, open} = 3'h7;
    wt(4);
    chk(drive, DRIVE_OFF);
    @(posedge clk_sys) reset_n <= 1;
    foreach (rows[i]) begin
      @(posedge clk_sys);
      open <= rows[i][0][0];
      dly <= rows[i][1][9:0];
      wt(240);
      chk(last_w, rows[i][2][15:0]);
    end
    chk(shoot, 0);
    chk((hi_n >= lo_n) && (hi_n <= lo_n + 8'h01), 1);
    @(posedge clk_sys);
    err <= 1;
    pwm_trip <= 1;
    wt(120);
    chk(last_w < 3, 1);
    @(posedge clk_sys);
    {err, pwm_trip, therm} <= 3'h1;
    wt(50);
    chk({drive, bias_enable, ssd}, 6'h01);
    m = hi_n;
    @(posedge clk_sys);
    therm <= 0;
    pp <= 1;
    wt(200);
    chk(hi_n != m, 1);
    chk(pp_act, 1);
    @(posedge clk_sys);
    bias_ready <= 0;
    wt(3);
    chk(drive, DRIVE_OFF);
    @(posedge clk_sys);
    bias_ready <= 1;
    wt(100);
    @(posedge clk_sys);
    clk_en <= 0;
    wt(2);
    held = drive;
    m = hi_n;
    wt(60);
    chk(drive, held);
    chk(hi_n, m);
    @(posedge clk_sys);
    clk_en <= 1;
    wt(200);
    chk(hi_n != m, 1);
    end_sim;
  end
endmodule : tb_hbop_phaser
`default_nettype wire
